/* logic/lod_regs.sv */
// Purpose: APB register bank for per-channel electrode lead-off detection
// Assumes: Single clock pclk at 200 MHz; zero-wait-state APB slave
// Notes: Status bytes are read-only; writes to them are ignored
//
// Functional notes
// - Positive enable mask at index 0x0F, bit k enables channel k+1.
// - Negative enable mask at index 0x10, bit k enables channel k+1.
// - Both enable masks and the swap byte reset to zero.
// - Channels 5-8 absent on four-channel, 7-8 absent on six-channel.
// - Swap byte at index 0x11 picks the pull direction per channel.
// - Swap clear pulls positive input high and negative input low.
// - Swap set pulls positive input low and negative input high.
// - Positive status at index 0x12 reads one for a detached lead.
// - Negative status at index 0x13 reads one for a detached lead.
`timescale 1ns/10ps
module lod_regs
    import lod_pkg::*;
#(
    parameter int NUM_CH = LOD_NUM_CH
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog front end
    input wire logic conv_strobe,
    input wire logic [7:0] pos_cmp_off,
    input wire logic [7:0] neg_cmp_off,
    output logic [7:0] pos_pull_high,
    output logic [7:0] pos_pull_low,
    output logic [7:0] neg_pull_high,
    output logic [7:0] neg_pull_low,
    // Interrupt
    output logic irq
);
    // ****************************************************************
    // Channel population
    // ****************************************************************
    localparam logic [7:0] CH_MASK = 8'(((1 << NUM_CH) - 1));

    logic [7:0] pos_detect_enable_r;
    logic [7:0] neg_detect_enable_r;
    logic [7:0] pull_polarity_swap_r;
    logic [7:0] pos_electrode_state;
    logic [7:0] neg_electrode_state;
    logic [7:0] pos_rise;
    logic [7:0] neg_rise;
    logic [LOD_IRQ_W-1:0] irq_status_r;
    logic [LOD_IRQ_W-1:0] irq_enable_r;
    logic [LOD_IRQ_W-1:0] irq_event;
    logic [LOD_IRQ_W-1:0] irq_clear;
    logic [9:0] word_idx;
    logic wr_en;
    logic rd_en;
    logic hit;
    logic [31:0] rdata_nxt;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    assign word_idx = paddr[11:2];
    assign wr_en = psel & penable & pwrite & pstrb[0];
    // Reads are captured in setup so the data stands in the access phase
    assign rd_en = psel & ~penable & ~pwrite;
    assign pready = 1'b1;

    always_comb begin
        hit = 1'b1;
        rdata_nxt = 32'h0000_0000;
        unique case (word_idx)
            {2'b00, LOD_IDX_POS_EN}:
                rdata_nxt[7:0] = pos_detect_enable_r;
            {2'b00, LOD_IDX_NEG_EN}:
                rdata_nxt[7:0] = neg_detect_enable_r;
            {2'b00, LOD_IDX_SWAP}:
                rdata_nxt[7:0] = pull_polarity_swap_r;
            {2'b00, LOD_IDX_POS_STATE}:
                rdata_nxt[7:0] = pos_electrode_state;
            {2'b00, LOD_IDX_NEG_STATE}:
                rdata_nxt[7:0] = neg_electrode_state;
            {2'b00, LOD_IDX_IRQ_STATUS}:
                rdata_nxt[LOD_IRQ_W-1:0] = irq_status_r;
            {2'b00, LOD_IDX_IRQ_ENABLE}:
                rdata_nxt[LOD_IRQ_W-1:0] = irq_enable_r;
            {2'b00, LOD_IDX_IRQ_CLEAR}:
                rdata_nxt = 32'h0000_0000;
            default:
                hit = 1'b0;
        endcase
    end

    // Unmapped access answers with an error, never a silent hit
    assign pslverr = psel & penable & ~hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata <= rdata_nxt;
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_detect_enable_r <= LOD_RST_POS_EN;
            neg_detect_enable_r <= LOD_RST_NEG_EN;
            pull_polarity_swap_r <= LOD_RST_SWAP;
        end else if (wr_en) begin
            // Absent channels read as zero and steer nothing
            if (word_idx == {2'b00, LOD_IDX_POS_EN}) begin
                pos_detect_enable_r <= pwdata[7:0] & CH_MASK;
            end
            if (word_idx == {2'b00, LOD_IDX_NEG_EN}) begin
                neg_detect_enable_r <= pwdata[7:0] & CH_MASK;
            end
            if (word_idx == {2'b00, LOD_IDX_SWAP}) begin
                pull_polarity_swap_r <= pwdata[7:0] & CH_MASK;
            end
        end
    end

    // ****************************************************************
    // Per-channel steering and status
    // ****************************************************************
    for (genvar k = 0; k < 8; k++) begin : g_ch
        lod_channel u_ch (
            .pclk(pclk),
            .presetn(presetn),
            .pos_en(pos_detect_enable_r[k]),
            .neg_en(neg_detect_enable_r[k]),
            .swap(pull_polarity_swap_r[k]),
            .implemented(CH_MASK[k]),
            .conv_strobe(conv_strobe),
            .pos_cmp_off(pos_cmp_off[k]),
            .neg_cmp_off(neg_cmp_off[k]),
            .pos_pull_high(pos_pull_high[k]),
            .pos_pull_low(pos_pull_low[k]),
            .neg_pull_high(neg_pull_high[k]),
            .neg_pull_low(neg_pull_low[k]),
            .pos_off_r(pos_electrode_state[k]),
            .neg_off_r(neg_electrode_state[k]),
            .pos_rise(pos_rise[k]),
            .neg_rise(neg_rise[k])
        );
    end

    // ****************************************************************
    // Interrupts: detach events, sticky until cleared
    // ****************************************************************
    assign irq_event = {neg_rise, pos_rise};
    assign irq_clear = (wr_en && word_idx == {2'b00, LOD_IDX_IRQ_CLEAR}) ?
        pwdata[LOD_IRQ_W-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable_r <= LOD_RST_IRQ;
        end else if (wr_en && word_idx == {2'b00, LOD_IDX_IRQ_ENABLE}) begin
            irq_enable_r <= pwdata[LOD_IRQ_W-1:0];
        end
    end

    // Set beats clear in the same cycle so no event is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_r <= LOD_RST_IRQ;
        end else begin
            irq_status_r <= (irq_status_r & ~irq_clear) | irq_event;
        end
    end

    assign irq = |(irq_status_r & irq_enable_r);
endmodule

/* logic/lod_pkg.sv */
// Purpose: Shared constants for the lead-off detection register bank
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes: Printed offsets are not all multiples of four, so they are indices
package lod_pkg;
    localparam int LOD_NUM_CH = 8;
    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [7:0] LOD_IDX_POS_EN = 8'h0F;
    localparam logic [7:0] LOD_IDX_NEG_EN = 8'h10;
    localparam logic [7:0] LOD_IDX_SWAP = 8'h11;
    localparam logic [7:0] LOD_IDX_POS_STATE = 8'h12;
    localparam logic [7:0] LOD_IDX_NEG_STATE = 8'h13;
    localparam logic [7:0] LOD_IDX_IRQ_STATUS = 8'h20;
    localparam logic [7:0] LOD_IDX_IRQ_ENABLE = 8'h21;
    localparam logic [7:0] LOD_IDX_IRQ_CLEAR = 8'h22;
    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] LOD_RST_POS_EN = 8'h00;
    localparam logic [7:0] LOD_RST_NEG_EN = 8'h00;
    localparam logic [7:0] LOD_RST_SWAP = 8'h00;
    localparam logic [7:0] LOD_RST_STATE = 8'h00;
    localparam logic [15:0] LOD_RST_IRQ = 16'h0000;
    // ****************************************************************
    // Interrupt field layout: positive detach in low byte
    // ****************************************************************
    localparam int LOD_IRQ_POS_LSB = 0;
    localparam int LOD_IRQ_NEG_LSB = 8;
    localparam int LOD_IRQ_W = 16;
endpackage

/* logic/lod_channel.sv */
// Purpose: One channel of lead-off pull steering and status capture
// Assumes: Comparator outputs synchronous to pclk
// Notes: Status updates only on a conversion strobe
`timescale 1ns/10ps
module lod_channel (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Configuration
    input wire logic pos_en,
    input wire logic neg_en,
    input wire logic swap,
    input wire logic implemented,
    // Analog side
    input wire logic conv_strobe,
    input wire logic pos_cmp_off,
    input wire logic neg_cmp_off,
    output logic pos_pull_high,
    output logic pos_pull_low,
    output logic neg_pull_high,
    output logic neg_pull_low,
    // Status
    output logic pos_off_r,
    output logic neg_off_r,
    output logic pos_rise,
    output logic neg_rise
);
    logic pos_act;
    logic neg_act;
    logic pos_nxt;
    logic neg_nxt;

    assign pos_act = pos_en & implemented;
    assign neg_act = neg_en & implemented;

    // Pulls only while that side is enabled
    assign pos_pull_high = pos_act & ~swap;
    assign neg_pull_low = neg_act & ~swap;
    assign pos_pull_low = pos_act & swap;
    assign neg_pull_high = neg_act & swap;

    // Disabled side holds its last value; software ignores it then
    assign pos_nxt = (conv_strobe && pos_act) ? pos_cmp_off : pos_off_r;
    assign neg_nxt = (conv_strobe && neg_act) ? neg_cmp_off : neg_off_r;
    assign pos_rise = pos_nxt & ~pos_off_r;
    assign neg_rise = neg_nxt & ~neg_off_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_off_r <= 1'b0;
            neg_off_r <= 1'b0;
        end else begin
            pos_off_r <= pos_nxt;
            neg_off_r <= neg_nxt;
        end
    end
endmodule

/* testbench/lod_regs_asserts.sv */
// Purpose: Port-level checks for the lead-off register bank
// Assumes: Zero-wait APB slave, read data registered
// Notes: Pull outputs expose the enable and swap bytes
`timescale 1ns/10ps
module lod_regs_asserts #(
    parameter int NUM_CH = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Front end
    input wire logic conv_strobe,
    input wire logic [7:0] pos_cmp_off,
    input wire logic [7:0] neg_cmp_off,
    input wire logic [7:0] pos_pull_high,
    input wire logic [7:0] pos_pull_low,
    input wire logic [7:0] neg_pull_high,
    input wire logic [7:0] neg_pull_low,
    input wire logic irq
);
    localparam logic [31:0] CHM = (32'h0000_0001 << NUM_CH) - 32'h0000_0001;
    wire wr = psel && penable && pwrite && pstrb[0];
    wire [9:0] idx = paddr[11:2];
    wire [31:0] pp = {24'h00_0000, pos_pull_high | pos_pull_low};
    wire [31:0] np = {24'h00_0000, neg_pull_high | neg_pull_low};
    wire [31:0] s0 = {24'h00_0000, pos_pull_low | neg_pull_high};
    wire [31:0] s1 = {24'h00_0000, pos_pull_high | neg_pull_low};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****************************************************************
    // Properties
    // ****************************************************************
    a_pos_en_wr: assert property (wr && idx == 10'h00f |=>
        pp == ($past(pwdata) & CHM)) else $error("pos enable not applied");
    a_neg_en_wr: assert property (wr && idx == 10'h010 |=>
        np == ($past(pwdata) & CHM)) else $error("neg enable not applied");
    a_reset_quiet: assert property ($rose(presetn) |->
        pp == 0 && np == 0 && !irq) else $error("not quiet after reset");
    a_absent_ch: assert property (((pp | np) & ~CHM) == 0)
        else $error("absent channel active");
    a_pull_excl: assert property (
        (pos_pull_high & pos_pull_low) == 0 &&
        (neg_pull_high & neg_pull_low) == 0) else $error("both pulls on");
    a_swap_clear: assert property (wr && idx == 10'h011 |=>
        (s0 & ~$past(pwdata)) == 0) else $error("unswapped pull wrong");
    a_swap_set: assert property (wr && idx == 10'h011 |=>
        (s1 & $past(pwdata)) == 0) else $error("swapped pull wrong");
    a_state_read: assert property (psel && penable && !pwrite &&
        (idx == 10'h012 || idx == 10'h013) |-> !pslverr ##1
        prdata[31:8] == 24'h00_0000) else $error("status read bad");
    a_ready_now: assert property (psel && !penable |=> pready[*1])
        else $error("access stalled");
endmodule
bind lod_regs lod_regs_asserts #(.NUM_CH(NUM_CH)) u_chk (.*);

/* testbench/lod_regs_tb_top.sv */
// Purpose: Self-checking bench for the lead-off register bank
// Assumes: APB read data stands at the completing edge
// Notes: Random masks with fixed seed plus all-ones corner
`timescale 1ns/10ps
module lod_regs_tb_top;
    import lod_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, conv_strobe, pready;
    logic pslverr, irq, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] pstrb;
    logic [7:0] pos_cmp_off, neg_cmp_off, ph, pl, nh, nl, a, b, c;
    logic [9:0] ri [6] = '{10'h00f, 10'h010, 10'h011, 10'h012, 10'h013,
        10'h020};
    int fails, n_checks;
    lod_regs #(.NUM_CH(8)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_strobe(conv_strobe),
        .pos_cmp_off(pos_cmp_off), .neg_cmp_off(neg_cmp_off),
        .pos_pull_high(ph), .pos_pull_low(pl), .neg_pull_high(nh),
        .neg_pull_low(nl), .irq(irq));
    initial begin
        pclk = 0;
        forever #2.5 pclk = ~pclk;
    end
    // ****************************************************************
    // Bus tasks and expectations
    // ****************************************************************
    task automatic xfer(input logic w, input logic [9:0] i,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= d;
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait ends once pready is high; only the watchdog ends a wait that gets no answer
        do @(posedge pclk); while (pready !== 1'b1);
        e = pslverr;
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] pulls(logic [7:0] p, n, s);
        return {p & ~s, p & s, n & s, n & ~s};
    endfunction
    task automatic test_done;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic conv(input logic [7:0] p, input logic [7:0] n);
        pos_cmp_off <= p;
        neg_cmp_off <= n;
        conv_strobe <= 1'b1;
        @(posedge pclk);
        conv_strobe <= 1'b0;
        @(posedge pclk);
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        test_done();
    end
    initial begin
        {presetn, psel, penable, pwrite, conv_strobe} = 5'h00;
        {paddr, pwdata, pstrb, pos_cmp_off, neg_cmp_off} = '0;
        fails = 0;
        n_checks = 0;
        void'($urandom(32'h8bda_54f1));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (ri[k]) begin
            xfer(1'b0, ri[k], 32'h0000_0000);
            chk(q, 32'h0000_0000);
        end
        $display("test reset done");
        for (int k = 0; k < 20; k++) begin
            a = (k == 0) ? 8'hff : 8'($urandom);
            b = 8'($urandom);
            c = (k == 1) ? 8'hff : 8'($urandom);
            xfer(1'b1, 10'h00f, {24'h00_0000, a});
            xfer(1'b1, 10'h010, {24'h00_0000, b});
            xfer(1'b1, 10'h011, {24'h00_0000, c});
            chk({ph, pl, nh, nl}, pulls(a, b, c));
            xfer(1'b0, 10'h00f, 32'h0000_0000);
            chk(q, {24'h00_0000, a});
            xfer(1'b0, 10'h010, 32'h0000_0000);
            chk(q, {24'h00_0000, b});
            xfer(1'b0, 10'h011, 32'h0000_0000);
            chk(q, {24'h00_0000, c});
        end
        $display("test config done");
        xfer(1'b1, 10'h00f, 32'h0000_00ff);
        xfer(1'b1, 10'h010, 32'h0000_00ff);
        a = 8'($urandom) | 8'h01;
        b = 8'($urandom) | 8'h80;
        conv(a, b);
        chk({31'h0, irq}, 32'h0000_0000);
        xfer(1'b0, 10'h012, 32'h0000_0000);
        chk(q, {24'h00_0000, a});
        xfer(1'b0, 10'h013, 32'h0000_0000);
        chk(q, {24'h00_0000, b});
        xfer(1'b1, 10'h012, 32'h0000_0000);
        xfer(1'b0, 10'h012, 32'h0000_0000);
        chk(q, {24'h00_0000, a});
        xfer(1'b0, 10'h020, 32'h0000_0000);
        chk(q, {16'h0000, b, a});
        xfer(1'b1, 10'h021, 32'h0000_ffff);
        chk({31'h0, irq}, 32'h0000_0001);
        xfer(1'b1, 10'h022, 32'h0000_ffff);
        chk({31'h0, irq}, 32'h0000_0000);
        xfer(1'b1, 10'h00f, 32'h0000_0000);
        conv(~a, b);
        xfer(1'b0, 10'h012, 32'h0000_0000);
        chk(q, {24'h00_0000, a});
        // Software view: only bits whose enable is set are looked at
        c = 8'($urandom);
        xfer(1'b1, 10'h00f, {24'h00_0000, c});
        xfer(1'b1, 10'h010, {24'h00_0000, ~c});
        conv(~a, ~b);
        xfer(1'b0, 10'h012, 32'h0000_0000);
        chk(q & {24'h00_0000, c}, {24'h00_0000, ~a & c});
        xfer(1'b0, 10'h013, 32'h0000_0000);
        chk(q & {24'h00_0000, ~c}, {24'h00_0000, ~b & ~c});
        xfer(1'b0, 10'h3ff, 32'h0000_0000);
        chk({31'h0, e}, 32'h0000_0001);
        chk(q, 32'h0000_0000);
        $display("test status done");
        test_done();
    end
endmodule
